// ===== hw/oad_decoder.v
// operand addressing decoder with axi4-lite register access
`timescale 1ns/100ps
module oad_decoder (
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire byte_valid,
  input wire [7:0] byte_data,
  output wire byte_ready,
  input wire string_dest,
  output reg dec_valid,
  output reg dec_illegal,
  output reg [7:0] dec_opcode,
  output reg [2:0] dec_group,
  output reg dec_dir,
  output reg dec_word,
  output reg dec_acc_imm,
  output reg dec_mem,
  output reg [15:0] dec_eff_addr,
  output reg [1:0] dec_seg,
  output reg [2:0] dec_reg_num,
  output reg dec_reg_hbyte,
  output reg [2:0] dec_rm_num,
  output reg dec_rm_hbyte,
  output reg [3:0] dec_sreg_sel,
  output reg [15:0] dec_imm
);
`include "oad_regs.vh"

  // one-hot decode states
  localparam [6:0] ST_OPC = 7'h01;
  localparam [6:0] ST_MRM = 7'h02;
  localparam [6:0] ST_DLO = 7'h04;
  localparam [6:0] ST_DHI = 7'h08;
  localparam [6:0] ST_ILO = 7'h10;
  localparam [6:0] ST_IHI = 7'h20;
  localparam [6:0] ST_EMIT = 7'h40;

  // software visible registers
  reg ctrl_en_r;
  reg [15:0] base_b_r;
  reg [15:0] base_ptr_r;
  reg [15:0] src_idx_r;
  reg [15:0] dst_idx_r;
  reg [15:0] count_r;

  // axi write side holding registers
  reg aw_hold_r;
  reg w_hold_r;
  reg [4:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;

  // decode state
  reg [6:0] state_r;
  reg [7:0] opc_r;
  reg [7:0] mrm_r;
  reg [7:0] dlo_r;
  reg [7:0] dhi_r;
  reg [7:0] ilo_r;
  reg [7:0] ihi_r;
  reg ovr_r;
  reg [1:0] ovr_seg_r;
  reg str_r;

  wire take;
  wire wr_go;
  wire [1:0] mode;
  wire [2:0] rm;
  wire direct;
  wire need_disp;
  wire need_hi;
  wire is_pfx;
  wire is_alu;
  wire [15:0] disp;
  wire [15:0] eff_addr;
  wire via_ptr;
  reg [1:0] seg_nxt;
  reg [31:0] rd_nxt;
  reg rd_ok;
  reg wr_ok;

  // merge a 16-bit register with the low two byte strobes
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge16 = old;
      for (i = 0; i < 2; i = i + 1) begin
        if (strb[i]) begin
          merge16[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // word registers map straight, byte registers fold high halves
  function [3:0] reg_map;
    input w;
    input [2:0] code;
    begin
      if (w) begin
        reg_map = {1'b0, code};
      end else begin
        reg_map = {code[2], 1'b0, code[1:0]};
      end
    end
  endfunction

  // axi write: address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // write decode, unmapped offsets answer slverr
  always @* begin
    case (aw_addr_r)
      `OAD_OFS_CTRL, `OAD_OFS_BASE_B, `OAD_OFS_BASE_PTR,
      `OAD_OFS_SRC_IDX, `OAD_OFS_DST_IDX: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // write channel and the registers it updates
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 5'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OAD_RESP_OKAY;
      ctrl_en_r <= `OAD_CTRL_RST;
      base_b_r <= `OAD_REG16_RST;
      base_ptr_r <= `OAD_REG16_RST;
      src_idx_r <= `OAD_REG16_RST;
      dst_idx_r <= `OAD_REG16_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `OAD_RESP_OKAY : `OAD_RESP_SLVERR;
        case (aw_addr_r)
          `OAD_OFS_CTRL: begin
            if (w_strb_r[0]) begin
              ctrl_en_r <= w_data_r[`OAD_CTRL_EN_BIT];
            end
          end
          `OAD_OFS_BASE_B:
            base_b_r <= merge16(base_b_r, w_data_r, w_strb_r);
          `OAD_OFS_BASE_PTR:
            base_ptr_r <= merge16(base_ptr_r, w_data_r, w_strb_r);
          `OAD_OFS_SRC_IDX:
            src_idx_r <= merge16(src_idx_r, w_data_r, w_strb_r);
          `OAD_OFS_DST_IDX:
            dst_idx_r <= merge16(dst_idx_r, w_data_r, w_strb_r);
          default: ctrl_en_r <= ctrl_en_r;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; status shows the last decoded result, but its override bit shows a pending prefix
  always @* begin
    rd_nxt = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OAD_OFS_CTRL: rd_nxt[`OAD_CTRL_EN_BIT] = ctrl_en_r;
      `OAD_OFS_BASE_B: rd_nxt[15:0] = base_b_r;
      `OAD_OFS_BASE_PTR: rd_nxt[15:0] = base_ptr_r;
      `OAD_OFS_SRC_IDX: rd_nxt[15:0] = src_idx_r;
      `OAD_OFS_DST_IDX: rd_nxt[15:0] = dst_idx_r;
      `OAD_OFS_STATUS: begin
        rd_nxt[`OAD_ST_ADDR_LSB +: 16] = dec_eff_addr;
        rd_nxt[`OAD_ST_SEG_LSB +: 2] = dec_seg;
        rd_nxt[`OAD_ST_ILL_BIT] = dec_illegal;
        rd_nxt[`OAD_ST_MEM_BIT] = dec_mem;
        rd_nxt[`OAD_ST_OVR_BIT] = ovr_r;
      end
      `OAD_OFS_COUNT: rd_nxt[15:0] = count_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel answers one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OAD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_nxt;
      s_axi_rresp <= rd_ok ? `OAD_RESP_OKAY : `OAD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // byte intake stalls while a result is emitted or decode is off
  assign byte_ready = ctrl_en_r && (state_r != ST_EMIT);
  assign take = byte_valid && byte_ready;

  // opcode classification
  assign is_pfx = (byte_data[7:5] == `OAD_PFX_TOP) &&
                  (byte_data[`OAD_OPC_LOW] == `OAD_PFX_LOW);
  assign is_alu = (byte_data[`OAD_OPC_ROW] == `OAD_ROW_ALU) &&
                  (byte_data[`OAD_OPC_GRP] <= `OAD_GRP_LAST) &&
                  (byte_data[`OAD_OPC_LOW] <= `OAD_LOW_LAST);

  // offset length from the mode of the incoming second byte
  assign need_disp = (byte_data[`OAD_MRM_MOD] == `OAD_MOD_DISP8) ||
    (byte_data[`OAD_MRM_MOD] == `OAD_MOD_DISP16) ||
    ((byte_data[`OAD_MRM_MOD] == `OAD_MOD_NODISP) &&
     (byte_data[`OAD_MRM_RM] == `OAD_RM_PTR));
  assign mode = mrm_r[`OAD_MRM_MOD];
  assign rm = mrm_r[`OAD_MRM_RM];
  assign direct = (mode == `OAD_MOD_NODISP) && (rm == `OAD_RM_PTR);
  assign need_hi = (mode == `OAD_MOD_DISP16) || direct;

  // one byte offsets are sign extended, mode 00 adds nothing except in the direct form
  assign disp = (mode == `OAD_MOD_DISP8) ? {{8{dlo_r[7]}}, dlo_r} :
                (need_hi ? {dhi_r, dlo_r} : `OAD_REG16_RST);

  oad_addr_calc u_addr (
    .mode(mode),
    .rm(rm),
    .base_reg_b(base_b_r),
    .base_pointer(base_ptr_r),
    .source_index(src_idx_r),
    .destination_index(dst_idx_r),
    .disp(disp),
    .effective_address(eff_addr),
    .via_ptr(via_ptr)
  );

  // segment choice: string destination beats override beats default
  always @* begin
    if (str_r) begin
      seg_nxt = `OAD_SEG_EXTRA;
    end else if (ovr_r) begin
      seg_nxt = ovr_seg_r;
    end else if (via_ptr) begin
      seg_nxt = `OAD_SEG_STACK;
    end else begin
      seg_nxt = `OAD_SEG_DATA;
    end
  end

  // byte sequencer: opcode, then either operand byte and offset, or data
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_OPC;
      opc_r <= 8'h00;
      mrm_r <= 8'h00;
      dlo_r <= 8'h00;
      dhi_r <= 8'h00;
      ilo_r <= 8'h00;
      ihi_r <= 8'h00;
      ovr_r <= 1'b0;
      ovr_seg_r <= `OAD_SEG_DATA;
      str_r <= 1'b0;
    end else begin
      case (state_r)
        ST_OPC: begin
          if (take) begin
            opc_r <= byte_data;
            mrm_r <= 8'hc0;
            ihi_r <= 8'h00;
            str_r <= string_dest;
            if (is_pfx) begin
              ovr_r <= 1'b1;
              ovr_seg_r <= byte_data[`OAD_PFX_SEG];
            end else if (!is_alu) begin
              state_r <= ST_EMIT;
            end else if (byte_data[`OAD_OPC_FORM] == `OAD_FORM_ACC) begin
              state_r <= ST_ILO;
            end else begin
              state_r <= ST_MRM;
            end
          end
        end
        ST_MRM: begin
          if (take) begin
            mrm_r <= byte_data;
            dlo_r <= 8'h00;
            dhi_r <= 8'h00;
            state_r <= need_disp ? ST_DLO : ST_EMIT;
          end
        end
        ST_DLO: begin
          if (take) begin
            dlo_r <= byte_data;
            state_r <= need_hi ? ST_DHI : ST_EMIT;
          end
        end
        ST_DHI: begin
          if (take) begin
            dhi_r <= byte_data;
            state_r <= ST_EMIT;
          end
        end
        ST_ILO: begin
          if (take) begin
            ilo_r <= byte_data;
            state_r <= opc_r[`OAD_OPC_WORD] ? ST_IHI : ST_EMIT;
          end
        end
        ST_IHI: begin
          if (take) begin
            ihi_r <= byte_data;
            state_r <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          ovr_r <= 1'b0;
          state_r <= ST_OPC;
        end
        default: state_r <= ST_OPC;
      endcase
    end
  end

  // result registers load once per instruction
  always @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid <= 1'b0;
      dec_illegal <= 1'b0;
      dec_opcode <= 8'h00;
      dec_group <= 3'h0;
      dec_dir <= 1'b0;
      dec_word <= 1'b0;
      dec_acc_imm <= 1'b0;
      dec_mem <= 1'b0;
      dec_eff_addr <= `OAD_REG16_RST;
      dec_seg <= `OAD_SEG_DATA;
      dec_reg_num <= 3'h0;
      dec_reg_hbyte <= 1'b0;
      dec_rm_num <= 3'h0;
      dec_rm_hbyte <= 1'b0;
      dec_sreg_sel <= 4'h0;
      dec_imm <= `OAD_REG16_RST;
      count_r <= 16'h0000;
    end else begin
      dec_valid <= (state_r == ST_EMIT);
      if (state_r == ST_EMIT) begin
        count_r <= count_r + 16'h0001;
        dec_opcode <= opc_r;
        dec_illegal <= !((opc_r[`OAD_OPC_ROW] == `OAD_ROW_ALU) &&
                         (opc_r[`OAD_OPC_GRP] <= `OAD_GRP_LAST) &&
                         (opc_r[`OAD_OPC_LOW] <= `OAD_LOW_LAST));
        dec_group <= opc_r[`OAD_OPC_GRP];
        dec_dir <= opc_r[`OAD_OPC_DIR];
        dec_word <= opc_r[`OAD_OPC_WORD];
        dec_acc_imm <= (opc_r[`OAD_OPC_FORM] == `OAD_FORM_ACC);
        dec_mem <= (mode != `OAD_MOD_REG);
        dec_eff_addr <= (mode != `OAD_MOD_REG) ? eff_addr :
                        `OAD_REG16_RST;
        dec_seg <= seg_nxt;
        {dec_reg_hbyte, dec_reg_num} <=
          reg_map(opc_r[`OAD_OPC_WORD], mrm_r[`OAD_MRM_REG]);
        {dec_rm_hbyte, dec_rm_num} <=
          reg_map(opc_r[`OAD_OPC_WORD], mrm_r[`OAD_MRM_RM]);
        // one-hot extra, code, stack, data from the segment field
        dec_sreg_sel <= 4'h1 << mrm_r[`OAD_MRM_SREG];
        dec_imm <= opc_r[`OAD_OPC_WORD] ? {ihi_r, ilo_r} :
                   {{8{ilo_r[7]}}, ilo_r};
      end
    end
  end
endmodule // oad_decoder

// ===== hw/oad_ea_calc.v
// effective address adder for the memory operand forms
`timescale 1ns/100ps
module oad_addr_calc (
  input wire [1:0] mode,
  input wire [2:0] rm,
  input wire [15:0] base_reg_b,
  input wire [15:0] base_pointer,
  input wire [15:0] source_index,
  input wire [15:0] destination_index,
  input wire [15:0] disp,
  output reg [15:0] effective_address,
  output reg via_ptr
);
`include "oad_regs.vh"

  wire direct;
  reg [15:0] base;
  reg [15:0] index;

  // the direct form replaces the base pointer row entirely
  assign direct = (mode == `OAD_MOD_NODISP) && (rm == `OAD_RM_PTR);

  // pick base and index, then one adder for every row
  always @* begin
    base = `OAD_REG16_RST;
    index = `OAD_REG16_RST;
    via_ptr = 1'b0;
    case (rm)
      `OAD_RM_BRB_SRC: begin
        base = base_reg_b;
        index = source_index;
      end
      `OAD_RM_BRB_DST: begin
        base = base_reg_b;
        index = destination_index;
      end
      `OAD_RM_PTR_SRC: begin
        base = base_pointer;
        index = source_index;
        via_ptr = 1'b1;
      end
      `OAD_RM_PTR_DST: begin
        base = base_pointer;
        index = destination_index;
        via_ptr = 1'b1;
      end
      `OAD_RM_SRC: index = source_index;
      `OAD_RM_DST: index = destination_index;
      `OAD_RM_PTR: begin
        base = direct ? `OAD_REG16_RST : base_pointer;
        via_ptr = !direct;
      end
      default: base = base_reg_b;
    endcase
    effective_address = base + index + disp;
  end
endmodule // oad_addr_calc

// ===== hw/oad_regs.vh
// constants for the operand addressing decoder and its register map
`ifndef OAD_REGS_VH
`define OAD_REGS_VH

// register byte offsets on the axi4-lite slave
`define OAD_OFS_CTRL 5'h00
`define OAD_OFS_BASE_B 5'h04
`define OAD_OFS_BASE_PTR 5'h08
`define OAD_OFS_SRC_IDX 5'h0c
`define OAD_OFS_DST_IDX 5'h10
`define OAD_OFS_STATUS 5'h14
`define OAD_OFS_COUNT 5'h18
`define OAD_ADDR_W 5

// control register fields and reset values
`define OAD_CTRL_EN_BIT 0
`define OAD_CTRL_RST 1'h1
`define OAD_REG16_RST 16'h0000

// status register field positions
`define OAD_ST_ADDR_LSB 0
`define OAD_ST_SEG_LSB 16
`define OAD_ST_ILL_BIT 18
`define OAD_ST_MEM_BIT 19
`define OAD_ST_OVR_BIT 20

// axi response codes
`define OAD_RESP_OKAY 2'h0
`define OAD_RESP_SLVERR 2'h2

// opcode fields
`define OAD_OPC_ROW 7:6
`define OAD_OPC_GRP 5:3
`define OAD_OPC_LOW 2:0
`define OAD_OPC_FORM 2:1
`define OAD_OPC_DIR 1
`define OAD_OPC_WORD 0
`define OAD_ROW_ALU 2'h0
`define OAD_GRP_LAST 3'h5
`define OAD_LOW_LAST 3'h5
`define OAD_FORM_ACC 2'h2
`define OAD_PFX_TOP 3'h1
`define OAD_PFX_LOW 3'h6
`define OAD_PFX_SEG 4:3

// second byte fields
`define OAD_MRM_MOD 7:6
`define OAD_MRM_REG 5:3
`define OAD_MRM_RM 2:0
`define OAD_MRM_SREG 4:3
`define OAD_MOD_NODISP 2'h0
`define OAD_MOD_DISP8 2'h1
`define OAD_MOD_DISP16 2'h2
`define OAD_MOD_REG 2'h3

// operand select codes
`define OAD_RM_BRB_SRC 3'h0
`define OAD_RM_BRB_DST 3'h1
`define OAD_RM_PTR_SRC 3'h2
`define OAD_RM_PTR_DST 3'h3
`define OAD_RM_SRC 3'h4
`define OAD_RM_DST 3'h5
`define OAD_RM_PTR 3'h6
`define OAD_RM_BRB 3'h7

// segment register codes
`define OAD_SEG_EXTRA 2'h0
`define OAD_SEG_CODE 2'h1
`define OAD_SEG_STACK 2'h2
`define OAD_SEG_DATA 2'h3

`endif

// ===== testbench/oad_fetch_model.sv
// behavioural instruction fetch feeding bytes to the decoder
`timescale 1ns/100ps
module oad_fetch_model (
  input wire aclk,
  input wire aresetn,
  input wire slow,
  input wire byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q [$];
  // bytes waiting to go out, oldest first
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // hold a byte until taken; slow rests a cycle between bytes
  always @(posedge aclk) begin
    if (!aresetn) begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else if (!byte_valid || byte_ready) begin
      if (byte_valid) void'(q.pop_front());
      if (q.size() != 0 && !(slow && byte_valid)) begin
        byte_valid <= 1'b1;
        byte_data <= q[0];
      end else begin
        byte_valid <= 1'b0;
        byte_data <= ~byte_data; // idle lines show the last byte inverted, then toggle every cycle
      end
    end
  end
endmodule // oad_fetch_model

// ===== testbench/oad_props.sv
// assertion checker watching the decoder's ports
`timescale 1ns/100ps
module oad_props (
  input wire aclk,
  input wire aresetn,
  input wire byte_valid,
  input wire [7:0] byte_data,
  input wire byte_ready,
  input wire string_dest,
  input wire dec_valid,
  input wire dec_illegal,
  input wire [2:0] dec_group,
  input wire dec_dir,
  input wire dec_word,
  input wire dec_mem,
  input wire [15:0] dec_eff_addr,
  input wire [1:0] dec_seg,
  input wire [2:0] dec_reg_num,
  input wire dec_reg_hbyte,
  input wire [3:0] dec_sreg_sel
);
  reg [1:0] n_r;
  reg [7:0] b0_r;
  reg [7:0] b1_r;
  reg sd_r;
  wire take = byte_valid && byte_ready;
  wire first = dec_valid || n_r == 2'h0;
  wire pfx = b0_r[7:5] == 3'h1 && b0_r[2:0] == 3'h6;
  wire bad = b0_r[7:6] != 2'h0 || b0_r[5:3] > 3'h5 || b0_r[2:0] > 3'h5;
  wire mrm = !pfx && !bad && !b0_r[2];
  wire ptr_row = b1_r[2:1] == 2'h1 ||
    (b1_r[2:0] == 3'h6 && b1_r[7:6] != 2'h0);
  // first two bytes of each instruction; a result restarts the capture
  always @(posedge aclk) begin
    if (!aresetn) begin
      n_r <= 2'h0;
    end else if (take) begin
      n_r <= first ? 2'h1 : 2'h2;
      if (first) begin
        b0_r <= byte_data;
        sd_r <= string_dest;
      end else if (n_r == 2'h1) begin
        b1_r <= byte_data;
      end
    end else if (dec_valid) begin
      n_r <= 2'h0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // one pulse per instruction, right after the refusal cycle
  sequence s_pulse;
    dec_valid ##1 !dec_valid;
  endsequence
  property p_emit;
    $fell(byte_ready) |=> s_pulse;
  endproperty
  a_emit: assert property (p_emit) else $error("result late");
  property p_grp;
    dec_valid && !pfx && !bad |-> dec_group == b0_r[5:3]
      && dec_dir == b0_r[1] && dec_word == b0_r[0];
  endproperty
  a_grp: assert property (p_grp) else $error("bad group");
  property p_ill;
    dec_valid && !pfx |-> dec_illegal == bad;
  endproperty
  a_ill: assert property (p_ill) else $error("bad illegal");
  property p_ea0;
    dec_valid && !dec_mem |-> dec_eff_addr == 16'h0000;
  endproperty
  a_ea0: assert property (p_ea0) else $error("ea not zero");
  property p_mode;
    dec_valid && mrm |-> dec_mem == (b1_r[7:6] != 2'h3);
  endproperty
  a_mode: assert property (p_mode) else $error("bad mem flag");
  property p_reg;
    dec_valid && mrm |-> dec_reg_hbyte == (!b0_r[0] && b1_r[5])
      && dec_reg_num == (b0_r[0] ? b1_r[5:3] : {1'b0, b1_r[4:3]});
  endproperty
  a_reg: assert property (p_reg) else $error("bad reg");
  property p_sreg;
    dec_valid && mrm |-> dec_sreg_sel == 4'h1 << b1_r[4:3];
  endproperty
  a_sreg: assert property (p_sreg) else $error("bad sreg");
  property p_bpseg;
    dec_valid && mrm && !sd_r && dec_mem && ptr_row |-> dec_seg == 2'h2;
  endproperty
  a_bpseg: assert property (p_bpseg) else $error("not stack");
  property p_str;
    dec_valid && dec_mem && sd_r |-> dec_seg == 2'h0;
  endproperty
  a_str: assert property (p_str) else $error("not extra");
endmodule // oad_props

// ===== testbench/tb_top.sv
// self-checking bench for the operand addressing decoder
`timescale 1ns/100ps
`include "oad_regs.vh"
module tb_top;
  localparam logic [15:0] base_b = 16'h1000, base_p = 16'h2000;
  localparam logic [15:0] src_i = 16'h0030, dst_i = 16'h0400;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, string_dest = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, dec_seg;
  wire [31:0] s_axi_rdata;
  wire byte_valid, byte_ready, dec_valid, dec_illegal, dec_dir, dec_word;
  wire dec_acc_imm, dec_mem, dec_reg_hbyte, dec_rm_hbyte;
  wire [7:0] byte_data, dec_opcode;
  wire [2:0] dec_group, dec_reg_num, dec_rm_num;
  wire [15:0] dec_eff_addr, dec_imm;
  wire [3:0] dec_sreg_sel;
  int num_errors = 0, checks_done = 0, n_dec = 0;
  oad_decoder u_dut (.*);
  oad_fetch_model u_fetch (.*);
  // 50 mhz clock
  always #10 aclk = ~aclk;
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // a wait that used up its bound ends the run
  task automatic hang(input int n);
    if (n >= 60) begin
      num_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      final_report();
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    hang(n);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic axi_rd(input logic [4:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    hang(n);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  // queue one instruction at the fetch side and wait for its result
  task automatic send(input logic [7:0] b [$], input logic sd);
    int n = 0;
    @(posedge aclk);
    string_dest <= sd;
    @(negedge aclk);
    foreach (b[i]) u_fetch.push(b[i]);
    do begin
      @(posedge aclk);
      n++;
    end while (!dec_valid && n < 60);
    hang(n);
    n_dec++;
  endtask
  // reset values, read-back, read-only and unmapped places
  task automatic t_regs;
    axi_rd(`OAD_OFS_CTRL, 32'h1, `OAD_RESP_OKAY);
    axi_rd(`OAD_OFS_COUNT, 32'h0, `OAD_RESP_OKAY);
    axi_wr(`OAD_OFS_BASE_B, 32'(base_b), `OAD_RESP_OKAY);
    axi_wr(`OAD_OFS_BASE_PTR, 32'(base_p), `OAD_RESP_OKAY);
    axi_wr(`OAD_OFS_SRC_IDX, 32'(src_i), `OAD_RESP_OKAY);
    axi_wr(`OAD_OFS_DST_IDX, 32'(dst_i), `OAD_RESP_OKAY);
    axi_rd(`OAD_OFS_BASE_PTR, 32'(base_p), `OAD_RESP_OKAY);
    axi_wr(`OAD_OFS_STATUS, 32'h0, `OAD_RESP_SLVERR);
    axi_wr(5'h1c, 32'h5, `OAD_RESP_SLVERR);
    axi_rd(5'h1c, 32'h0, `OAD_RESP_SLVERR);
  endtask
  // every operand select, with a slow fetch side
  task automatic t_ea;
    logic [15:0] e [8] = '{base_b + src_i, base_b + dst_i, base_p + src_i,
      base_p + dst_i, src_i, dst_i, base_p, base_b};
    @(posedge aclk);
    slow <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      send('{8'h01, {5'b10000, 3'(r)}, 8'h34, 8'h12}, 1'b0);
      chk(32'(dec_eff_addr), 32'(e[r] + 16'h1234));
      chk(32'(dec_seg), (r inside {2, 3, 6}) ? 32'h2 : 32'h3);
    end
    send('{8'h03, 8'h46, 8'h80}, 1'b0);
    chk(32'(dec_eff_addr), 32'(base_p - 16'h0080));
    send('{8'h03, 8'h06, 8'h34, 8'h12}, 1'b0);
    chk(32'(dec_eff_addr), 32'h1234);
    chk(32'(dec_seg), 32'h3);
    send('{8'h02, 8'h01}, 1'b1);
    chk(32'(dec_eff_addr), 32'(base_b + dst_i));
    chk(32'(dec_seg), 32'h0);
    send('{8'h3e, 8'h02, 8'h05}, 1'b1);
    chk(32'(dec_seg), 32'h0);
    slow <= 1'b0;
    // status holds the last result: address, extra segment, memory form
    axi_rd(`OAD_OFS_STATUS, 32'h00080400, `OAD_RESP_OKAY);
  endtask
  // register operands, byte halves and prefix segments
  task automatic t_regf;
    for (int w = 0; w < 2; w++) begin
      send('{8'(w), 8'hea}, 1'b0);
      chk(32'(dec_reg_num), w ? 32'h5 : 32'h1);
      chk(32'(dec_reg_hbyte), 32'(w == 0));
      chk(32'(dec_rm_num), 32'h2);
      chk(32'(dec_rm_hbyte), 32'h0);
      chk(32'(dec_mem), 32'h0);
    end
    for (int s = 0; s < 4; s++) begin
      send('{8'h26 | 8'(s << 3), 8'h00, 8'(s << 3)}, 1'b0);
      chk(32'(dec_seg), 32'(s));
      chk(32'(dec_sreg_sel), 32'(1 << s));
    end
  endtask
  // every code below 42h except the prefixes, legal and not
  task automatic t_ops;
    logic [7:0] op;
    logic ill;
    for (int i = 0; i < 8'h42; i++) begin
      op = 8'(i);
      ill = op[7:6] != 2'h0 || op[5:3] > 3'h5 || op[2:0] > 3'h5;
      if (op[7:5] == 3'h1 && op[2:0] == 3'h6) continue;
      if (ill) send('{op}, 1'b0);
      else if (op[2:0] == 3'h5) send('{op, 8'h34, 8'h12}, 1'b0);
      else if (op[2:0] == 3'h4) send('{op, 8'h85}, 1'b0);
      else send('{op, 8'hc0}, 1'b0);
      chk(32'(dec_illegal), 32'(ill));
      chk(32'(dec_opcode), 32'(op));
      if (!ill) begin
        chk(32'({dec_group, dec_dir, dec_word}),
            32'({op[5:3], op[1:0]}));
        chk(32'(dec_acc_imm), 32'(op[2]));
        if (op[2]) chk(32'(dec_imm), op[0] ? 32'h1234 : 32'hff85);
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ea();
    t_regf();
    t_ops();
    axi_rd(`OAD_OFS_COUNT, 32'(n_dec), `OAD_RESP_OKAY);
    final_report();
  end
endmodule // tb_top
bind oad_decoder oad_props u_props (.*);
